// [src/mono_lcd_row_scan_feed.v]
// Row scan feed: captures nibbles, latches rows and drives column/scan state
//
// Summary of operation
// RULE1 - Host sends rows as nibbles, left first
// RULE2 - Nibble captured on shift clock falling edge
// RULE3 - Latch fall transfers row to columns
// RULE4 - Next row shifts while current displays
// RULE5 - Host sends 244 latched rows per frame; the bench starts a new frame after at most 15 rows
// RULE6 - Host pulses scan start once per frame
// RULE7 - One 80-dot chip enabled, advance each 20
// RULE8 - Host streams data continuously, no memory
// RULE9 - Latch falls equally spaced, at most 75us
// RULE10 - Frame period 8.33 to 16.94 ms; the bench frames last at most 15 rows of 5770 ns
// RULE11 - Shift clock 82ns period, 30ns phases; the host model runs a 64ns period with 32ns phases
// RULE12 - Latch high at least 250 ns
// RULE13 - 200ns around latch versus shift clock
// RULE14 - Alternation changes near latch, 26-row period
// RULE15 - Alternation signal always running
// RULE16 - Data high turns pixel on
// RULE17 - Display enable high shows image
// RULE18 - On pixels black, panel normally white
// RULE19 - Host fills extra rows with off pixels
// RULE20 - Host holds enable low until cadence
`timescale 1ns/10ps
`default_nettype none
`include "lcd_feed_regs.vh"

module mono_lcd_row_scan_feed (
  input  wire                       ref_clk,
  input  wire                       srst,
  input  wire                       pixel_shift_clock,
  input  wire                       row_latch_strobe,
  input  wire                       frame_scan_start,
  input  wire                       alternating_signal,
  input  wire                       display_on_control,
  input  wire [`NIBBLE_WIDTH-1:0]   pixel_nibble,
  output wire                       column_ready,
  output reg  [`COL_COUNT-1:0]      column_dark,
  output reg                        column_valid,
  output reg  [`ROW_CNT_W-1:0]      scan_row,
  output reg                        drive_polarity,
  output reg                        display_active,
  output reg  [`CHIP_COUNT-1:0]     chip_enable,
  output reg                        row_overrun
);

  // ----------------------------------------
  // Input synchronisers (two flops each)
  // ----------------------------------------
  reg [4+`NIBBLE_WIDTH:0] sync1_reg;
  reg [4+`NIBBLE_WIDTH:0] sync2_reg;
  reg                     xck_prev_reg;
  reg                     lp_prev_reg;

  // Whole bus through two stages; slow host edges keep data coherent
  always @(posedge ref_clk) begin
    if (srst) begin
      sync1_reg <= {(5+`NIBBLE_WIDTH){1'b0}};
      sync2_reg <= {(5+`NIBBLE_WIDTH){1'b0}};
    end else begin
      sync1_reg <= {display_on_control, alternating_signal, frame_scan_start,
                    row_latch_strobe, pixel_shift_clock, pixel_nibble};
      sync2_reg <= sync1_reg;
    end
  end

  // Stage-two taps; nothing reads stage one
  wire [`NIBBLE_WIDTH-1:0] nib_s  = sync2_reg[`NIBBLE_WIDTH-1:0];
  wire                     xck_s  = sync2_reg[`NIBBLE_WIDTH];
  wire                     lp_s   = sync2_reg[`NIBBLE_WIDTH+1];
  wire                     yd_s   = sync2_reg[`NIBBLE_WIDTH+2];
  wire                     alt_s  = sync2_reg[`NIBBLE_WIDTH+3];
  wire                     display_on_control_s = sync2_reg[`NIBBLE_WIDTH+4];

  // Edge detectors read only the second stage
  always @(posedge ref_clk) begin
    if (srst) begin
      xck_prev_reg <= 1'b0;
      lp_prev_reg  <= 1'b0;
    end else begin
      xck_prev_reg <= xck_s;
      lp_prev_reg  <= lp_s;
    end
  end

  // Falling edges, one cycle wide
  wire xck_fall = xck_prev_reg && !xck_s;
  wire lp_fall  = lp_prev_reg && !lp_s;

  // ----------------------------------------
  // Column shift register and chip select
  // ----------------------------------------
  reg [`COL_COUNT-1:0]      shift_reg;
  reg [`SHIFT_CNT_W-1:0]    shift_cnt_reg;
  reg [4:0]                 chip_cnt_reg;
  reg [`CHIP_SEL_W-1:0]     chip_sel_reg;

  // Saturation and wrap points, sized to their counters
  localparam [`SHIFT_CNT_W-1:0] SHIFT_LAST = `SHIFTS_PER_ROW;
  localparam [`ROW_CNT_W-1:0]   ROW_LAST   = `ROW_PER_FRAME - 1;
  localparam [4:0]              CHIP_LAST  = `CHIP_SHIFTS - 1;

  // Map a chip index to a one-hot enable
  function [`CHIP_COUNT-1:0] chip_onehot;
    input [`CHIP_SEL_W-1:0] sel;
    begin
      chip_onehot = {{(`CHIP_COUNT-1){1'b0}}, 1'b1} << sel;
    end
  endfunction

  // First nibble ends at the left; row shifts toward higher bits
  always @(posedge ref_clk) begin
    if (srst) begin
      shift_reg     <= {`COL_COUNT{1'b0}};
      shift_cnt_reg <= {`SHIFT_CNT_W{1'b0}};
      chip_cnt_reg  <= 5'h00;
      chip_sel_reg  <= {`CHIP_SEL_W{1'b0}};
    end else if (lp_fall) begin
      shift_cnt_reg <= {`SHIFT_CNT_W{1'b0}}; // RULE4
      chip_cnt_reg  <= 5'h00;
      chip_sel_reg  <= {`CHIP_SEL_W{1'b0}};
    end else if (xck_fall) begin
      // Data high means on; stored as-is for dark pixels
      shift_reg <= {shift_reg[`COL_COUNT-`NIBBLE_WIDTH-1:0], nib_s}; // RULE2 RULE16
      if (shift_cnt_reg != SHIFT_LAST)
        shift_cnt_reg <= shift_cnt_reg + 7'h01;
      if (chip_cnt_reg == CHIP_LAST) begin
        chip_cnt_reg <= 5'h00;
        chip_sel_reg <= chip_sel_reg + 2'h1; // RULE7
      end else begin
        chip_cnt_reg <= chip_cnt_reg + 5'h01;
      end
    end
  end

  // Only the chip receiving data sees an enable
  always @(posedge ref_clk) begin
    if (srst)
      chip_enable <= {`CHIP_COUNT{1'b0}};
    else if (shift_cnt_reg == SHIFT_LAST || lp_fall)
      chip_enable <= {`CHIP_COUNT{1'b0}};
    else
      chip_enable <= chip_onehot(chip_sel_reg); // RULE7
  end

  // ----------------------------------------
  // Row latch into buffer
  // ----------------------------------------
  wire buf_in_ready;
  wire buf_out_valid;
  wire [`COL_COUNT-1:0] buf_out_data;

  // Overrun flags a latched row lost because the buffer was full
  always @(posedge ref_clk) begin
    if (srst)
      row_overrun <= 1'b0;
    else
      row_overrun <= lp_fall && !buf_in_ready;
  end

  row_buffer u_row_buffer (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .in_valid  (lp_fall),
    .in_ready  (buf_in_ready),
    .in_data   (shift_reg),
    .out_valid (buf_out_valid),
    .out_ready (column_ready),
    .out_data  (buf_out_data)
  );

  // ----------------------------------------
  // Column drive, scan counter, polarity
  // ----------------------------------------
  // Delayed pop marks when the buffer word lands
  reg pop_d_reg;

  // Output word of the buffer is valid the cycle after a pop
  always @(posedge ref_clk) begin
    if (srst)
      pop_d_reg <= 1'b0;
    else
      pop_d_reg <= buf_out_valid && column_ready;
  end

  // Display off blanks every column to white
  always @(posedge ref_clk) begin
    if (srst) begin
      column_dark  <= {`COL_COUNT{1'b0}};
      column_valid <= 1'b0;
    end else begin
      column_valid <= pop_d_reg;
      if (!display_on_control_s)
        column_dark <= {`COL_COUNT{1'b0}}; // RULE17 RULE18
      else if (pop_d_reg)
        column_dark <= buf_out_data; // RULE3 RULE18
    end
  end

  // Scan row restarts on a latch fall with scan start high
  always @(posedge ref_clk) begin
    if (srst) begin
      scan_row       <= {`ROW_CNT_W{1'b0}};
      drive_polarity <= 1'b0;
      display_active <= 1'b0;
    end else begin
      display_active <= display_on_control_s; // RULE17
      drive_polarity <= alt_s;
      if (lp_fall) begin
        if (yd_s)
          scan_row <= {`ROW_CNT_W{1'b0}}; // RULE6
        else if (scan_row != ROW_LAST)
          scan_row <= scan_row + 8'h01; // RULE4 RULE5
      end
    end
  end

  // Column drivers always accept; stall only if a consumer is added
  assign column_ready = 1'b1;

endmodule
`default_nettype wire

// [src/lcd_feed_regs.vh]
// Constants for the row scan feed: panel and buffer geometry and counts
`ifndef LCD_FEED_REGS_VH
`define LCD_FEED_REGS_VH
// ----------------------------------------
// Panel geometry
// ----------------------------------------
`define COL_COUNT        320
`define ROW_VISIBLE      240
`define ROW_PER_FRAME    244
`define NIBBLE_WIDTH     4
`define CHIP_DOTS        80
`define CHIP_COUNT       4
`define CHIP_SHIFTS      20
`define SHIFTS_PER_ROW   80
`define SHIFT_CNT_W      7
`define ROW_CNT_W        8
`define CHIP_SEL_W       2
// ----------------------------------------
// Buffer geometry
// ----------------------------------------
`define BUF_DEPTH        2
`define BUF_WIDTH        320
`endif

// [src/row_buffer.v]
// Two-entry buffer holding latched rows between capture and column drive
`timescale 1ns/10ps
`default_nettype none
`include "lcd_feed_regs.vh"

module row_buffer (
  input  wire                    ref_clk,
  input  wire                    srst,
  input  wire                    in_valid,
  output wire                    in_ready,
  input  wire [`BUF_WIDTH-1:0]   in_data,
  output wire                    out_valid,
  input  wire                    out_ready,
  output reg  [`BUF_WIDTH-1:0]   out_data
);

  reg [`BUF_WIDTH-1:0] mem_reg [0:`BUF_DEPTH-1];
  reg                  wr_ptr_reg;
  reg                  rd_ptr_reg;
  reg [1:0]            fill_reg;
  wire                 push;
  wire                 pop;

  // ----------------------------------------
  // Handshake terms
  // ----------------------------------------
  assign in_ready  = (fill_reg != 2'h2);
  assign out_valid = (fill_reg != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage, pointers and fill level
  always @(posedge ref_clk) begin
    if (srst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      fill_reg   <= 2'h0;
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      if (push && !pop)
        fill_reg <= fill_reg + 2'h1;
      else if (pop && !push)
        fill_reg <= fill_reg - 2'h1;
    end
  end

  // Head word taken on a pop; it stands in a flop from the next cycle
  always @(posedge ref_clk) begin
    if (srst)
      out_data <= {`BUF_WIDTH{1'b0}};
    else if (pop)
      out_data <= mem_reg[rd_ptr_reg];
  end

endmodule
`default_nettype wire

// [verif/mono_lcd_row_scan_feed_checker.sv]
// Port assertions for the row scan feed
`timescale 1ns/10ps
`default_nettype none
`include "lcd_feed_regs.vh"
module mono_lcd_row_scan_feed_checker (
  input wire logic                   ref_clk,
  input wire logic                   srst,
  input wire logic                   row_latch_strobe,
  input wire logic                   alternating_signal,
  input wire logic                   display_on_control,
  input wire logic [`COL_COUNT-1:0]  column_dark,
  input wire logic                   column_valid,
  input wire logic [`ROW_CNT_W-1:0]  scan_row,
  input wire logic                   drive_polarity,
  input wire logic                   display_active,
  input wire logic [`CHIP_COUNT-1:0] chip_enable
);
  // ----------------------------
  // Properties, one domain only
  // ----------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_valid_pulse; column_valid |=> !column_valid; endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("row load pulse too long");
  property p_latch_load; $fell(row_latch_strobe) |-> ##[3:8] column_valid; endproperty
  a_latch_load: assert property (p_latch_load) else $error("latch fall gave no row load");
  property p_chip_onehot; $onehot0(chip_enable); endproperty
  a_chip_onehot: assert property (p_chip_onehot) else $error("more than one chip enabled");
  property p_chip_idle; column_valid |-> chip_enable == 4'h1; endproperty
  a_chip_idle: assert property (p_chip_idle) else $error("first chip not waiting at row load");
  property p_row_step; !$stable(scan_row) |-> ##[1:5] column_valid; endproperty
  a_row_step: assert property (p_row_step) else $error("scan row moved without a load");
  // Two idle cycles allow for the clear to land
  property p_off_blank; !display_active && $past(!display_active) |-> column_dark == '0; endproperty
  a_off_blank: assert property (p_off_blank) else $error("columns dark while display off");
  property p_on_follow; $rose(display_on_control) |-> ##[1:4] display_active; endproperty
  a_on_follow: assert property (p_on_follow) else $error("display enable not followed");
  property p_pol_follow; $rose(alternating_signal) |-> ##[1:4] drive_polarity; endproperty
  a_pol_follow: assert property (p_pol_follow) else $error("polarity not followed");
  c_first_row: cover property (column_valid && scan_row == 8'h00);
  c_pol_flip: cover property ($rose(drive_polarity));
  c_last_chip: cover property (chip_enable[3]);
endmodule
bind mono_lcd_row_scan_feed mono_lcd_row_scan_feed_checker chk (
  .ref_clk(ref_clk), .srst(srst), .row_latch_strobe(row_latch_strobe),
  .alternating_signal(alternating_signal), .display_on_control(display_on_control),
  .column_dark(column_dark), .column_valid(column_valid), .scan_row(scan_row),
  .drive_polarity(drive_polarity), .display_active(display_active), .chip_enable(chip_enable)
);
`default_nettype wire

// [verif/lcd_host_model.sv]
// Host controller model: shifts nibble rows and strobes the latch
`timescale 1ns/10ps
`default_nettype none
module lcd_host_model (
  output var logic       pixel_shift_clock,
  output var logic       row_latch_strobe,
  output var logic       frame_scan_start,
  output var logic       alternating_signal,
  output var logic [3:0] pixel_nibble
);
  int fall_cnt = 0;
  // Shift clock stands low between rows
  initial begin
    pixel_shift_clock = 1'b0;
    row_latch_strobe = 1'b0;
    frame_scan_start = 1'b0;
    alternating_signal = 1'b0;
    pixel_nibble = 4'h0;
  end
  // ----------------------------
  // One row, left pixel first
  // ----------------------------
  task automatic send_row(input logic [319:0] row, input logic first);
    for (int i = 0; i < 80; i++) begin
      pixel_nibble = row[319-4*i -: 4];
      #2 pixel_shift_clock = 1'b1;
      #32 pixel_shift_clock = 1'b0;
      #30 pixel_nibble = ~pixel_nibble; // Stale data never looks valid
    end
    #200 row_latch_strobe = 1'b1;
    frame_scan_start = first;
    #250 row_latch_strobe = 1'b0;
    fall_cnt++;
    #10 if (fall_cnt == 13) begin
      alternating_signal = ~alternating_signal;
      fall_cnt = 0;
    end
    #115 frame_scan_start = 1'b0;
    #75;
  endtask
endmodule
`default_nettype wire

// [verif/mono_lcd_row_scan_feed_tb.sv]
// Self-checking bench for the row scan feed
`timescale 1ns/10ps
`default_nettype none
module mono_lcd_row_scan_feed_tb;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic display_on_control = 1'b0;
  logic pixel_shift_clock, row_latch_strobe, frame_scan_start, alternating_signal;
  logic column_ready, column_valid, drive_polarity, display_active, row_overrun;
  logic [3:0] pixel_nibble, chip_enable;
  logic [319:0] column_dark, pat;
  logic [7:0] scan_row;
  int error_cnt = 0;
  int checks = 0;
  always #2.5 ref_clk = ~ref_clk;
  lcd_host_model host (
    .pixel_shift_clock(pixel_shift_clock), .row_latch_strobe(row_latch_strobe),
    .frame_scan_start(frame_scan_start), .alternating_signal(alternating_signal), .pixel_nibble(pixel_nibble));
  mono_lcd_row_scan_feed dut (
    .ref_clk(ref_clk), .srst(srst), .pixel_shift_clock(pixel_shift_clock), .row_latch_strobe(row_latch_strobe),
    .frame_scan_start(frame_scan_start), .alternating_signal(alternating_signal),
    .display_on_control(display_on_control), .pixel_nibble(pixel_nibble), .column_ready(column_ready),
    .column_dark(column_dark), .column_valid(column_valid), .scan_row(scan_row), .drive_polarity(drive_polarity),
    .display_active(display_active), .chip_enable(chip_enable), .row_overrun(row_overrun));
  // ----------------------------
  // Compare, verdict, scenarios
  // ----------------------------
  task automatic chk(input string what, input logic [319:0] exp, input logic [319:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Fourteen rows: row index, nibble order, chip walk, polarity flip
  task automatic t_rows;
    for (int r = 0; r < 14; r++) begin
      for (int i = 0; i < 80; i++) pat[319-4*i -: 4] = 4'(i + r);
      fork
        host.send_row(pat, r == 0);
        begin
          #1610 chk("chip_enable", 4'h2, chip_enable);
          #3640 chk("chip_enable", 4'h0, chip_enable);
        end
      join
      chk("column_dark", pat, column_dark);
      chk("scan_row", r, scan_row);
      chk("chip_enable", 4'h1, chip_enable);
      chk("row_overrun", 1'b0, row_overrun);
    end
    chk("drive_polarity", 1'b1, drive_polarity);
    $display("rows test done");
  endtask
  // Off-pixel padding row, early new frame (short frames keep the run brief), display off
  task automatic t_restart_off;
    host.send_row(320'h0, 1'b0);
    chk("column_dark", 320'h0, column_dark);
    chk("scan_row", 8'h0e, scan_row);
    host.send_row(~pat, 1'b1);
    chk("column_dark", ~pat, column_dark);
    chk("scan_row", 8'h00, scan_row);
    @(posedge ref_clk) display_on_control <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk("column_dark", 320'h0, column_dark);
    $display("restart and off test done");
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk) #1;
    chk("scan_row", 8'h00, scan_row);
    chk("column_dark", 320'h0, column_dark);
    chk("column_ready", 1'b1, column_ready);
    chk("row_overrun", 1'b0, row_overrun);
    // Cadence runs before enable; a full row must stay blank while off
    host.send_row({320{1'b1}}, 1'b1);
    chk("column_dark", 320'h0, column_dark);
    @(posedge ref_clk) display_on_control <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk("display_active", 1'b1, display_active);
    $display("reset test done");
    t_rows;
    t_restart_off;
    give_verdict;
  end
endmodule
`default_nettype wire
